// file: core/u2ub_core.sv
/*
  Serial bridge core: APB register face standing for the USB function's
  request path, 64-byte transmit and receive buffers, 8N1 UART with RTS/CTS.
  Assumes pclk at 100 MHz, presetn asynchronous active low, and rx / cts_n
  arriving asynchronously from the serial peer.
*/
// What this block does
// - Presents two functions after reset: control/configuration and serial data.
// - Configuration changes only through host requests, never from serial data.
// - One controller moves data both ways and services host requests.
// - Control function carries configuration and identity; serial function carries data only.
// - Frame fixed at 8N1; rate defaults to 19200 unless a start rate replaces it.
// - Line coding read returns settings; set changes only the baud rate.
// - Divisor is integer 12 MHz over requested rate, clamped to at least 1.
// - Primary rates 300 to 19200 exact, higher ones approximated.
// - Any nonzero requested rate written while the divider is idle is accepted through the same division.
// - Two 64-byte buffers, one per direction.
// - RTS output is active low, low while fewer than 63 characters are buffered.
// - RTS goes high once 63 unread characters are buffered.
// - CTS is sampled before each character starts; high holds the character.
// - A started character always completes whatever CTS does.
// - Full receive buffer keeps its pointer; new data overwrites the last entry.
// - RTS/CTS handshake is selectable and applies only when enabled.
// - Suspend is entered when bus suspend is detected with no exit event in the same request.
// - Suspend ends on resume, wake, bus reset or device reset.
// - Vendor and product identifiers live in writable on-chip storage.
// - A 12 MHz reference tick drives bit timing and is the divisor numerator.
`timescale 1ns/1ps
module u2ub_core
	import u2ub_pkg::*;
#(
	parameter logic [31:0] START_RATE_P = START_RATE,
	parameter logic [15:0] VENDOR_ID    = 16'h1234,  // Arbitrary value
	parameter logic [15:0] PRODUCT_ID   = 16'h5678   // Arbitrary value
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial port
	input  wire logic        rx,
	output logic             tx,
	input  wire logic        cts_n,
	output logic             rts_n
);

	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic              flow_en;
		logic              suspended;
		logic [31:0]       rate;
		logic [23:0]       div;
		logic [31:0]       ident;
		logic              div_busy;
		logic [4:0]        div_step;
		logic [23:0]       quo;
		logic [32:0]       rem;
		logic [31:0]       req_rate;
		logic [7:0]        ref_acc;
		logic              ref_tick;
		logic [63:0][7:0]  txm;
		logic [5:0]        tx_rd;
		logic [6:0]        tx_cnt;
		logic [63:0][7:0]  rxm;
		logic [5:0]        rx_rd;
		logic [6:0]        rx_cnt;
		u2ub_tx_st_t       tx_st;
		logic [23:0]       tx_bc;
		logic [2:0]        tx_bit;
		logic [7:0]        tx_sh;
		logic              txd;
		u2ub_rx_st_t       rx_st;
		logic [23:0]       rx_bc;
		logic [2:0]        rx_bit;
		logic [7:0]        rx_sh;
		logic [2:0]        rx_sync;
		logic [1:0]        cts_sync;
		logic              rts_n;
		logic              tx_drop;
		logic              rx_ovf;
	} u2ub_state_t;

	u2ub_state_t s_q;
	u2ub_state_t s_d;

	function automatic logic [5:0] ring_idx(input logic [5:0] base, input logic [6:0] off);
		return base + off[5:0];
	endfunction

	function automatic logic [6:0] cnt_next(input logic [6:0] c, input logic inc,
			input logic dec);
		return c + {6'h00, inc} - {6'h00, dec};
	endfunction

	always_comb begin
		logic [7:0]  acc_sum;
		logic [32:0] rem_sh;
		logic        access;
		logic        commit;
		logic        tx_push;
		logic        tx_pop;
		logic        rx_push;
		logic        rx_pop;
		logic        cts_clear;
		acc_sum   = '0;
		rem_sh    = '0;
		tx_push   = 1'b0;
		tx_pop    = 1'b0;
		rx_push   = 1'b0;
		rx_pop    = 1'b0;
		s_d       = s_q;
		access    = psel & penable;
		commit    = access & s_q.pready;
		cts_clear = ~s_q.flow_en | ~s_q.cts_sync[1];

		// Synchronisers: stage 0 feeds stage 1 only
		s_d.rx_sync  = {s_q.rx_sync[1:0], rx};
		s_d.cts_sync = {s_q.cts_sync[0], cts_n};

		// Fractional 12 MHz tick from 100 MHz: 12 ticks per 100 cycles
		acc_sum = s_q.ref_acc + REF_MHZ;
		s_d.ref_tick = 1'b0;
		if (acc_sum >= CLK_MHZ) begin
			s_d.ref_acc  = acc_sum - CLK_MHZ;
			s_d.ref_tick = 1'b1;
		end else begin
			s_d.ref_acc = acc_sum;
		end

		// APB: one wait state, answer registered from the first access cycle
		s_d.pready  = access & ~s_q.pready;
		s_d.pslverr = 1'b0;
		if (access & ~s_q.pready) begin
			s_d.prdata = '0;
			case (paddr)
				OFS_CTRL:    s_d.prdata[B_FLOW_EN] = s_q.flow_en;
				OFS_USB_EVT: s_d.prdata[B_EV_SUSP] = s_q.suspended;
				OFS_RATE:    s_d.prdata = s_q.rate;
				OFS_FMT:     s_d.prdata = FMT_WORD;
				OFS_DIV:     s_d.prdata = {8'h00, s_q.div};
				OFS_TXDATA:  s_d.prdata = '0;
				OFS_RXDATA: begin
					s_d.prdata[7:0]        = s_q.rxm[s_q.rx_rd];
					s_d.prdata[B_RX_VALID] = (s_q.rx_cnt != '0);
				end
				OFS_STATUS: begin
					s_d.prdata[6:0]         = s_q.tx_cnt;
					s_d.prdata[14:8]        = s_q.rx_cnt;
					s_d.prdata[B_ST_SUSP]   = s_q.suspended;
					s_d.prdata[B_ST_BUSY]   = s_q.div_busy;
					s_d.prdata[B_ST_CTS]    = s_q.cts_sync[1];
					s_d.prdata[B_ST_RTS]    = s_q.rts_n;
					s_d.prdata[B_ST_TXDROP] = s_q.tx_drop;
					s_d.prdata[B_ST_RXOVF]  = s_q.rx_ovf;
					s_d.prdata[25:24]       = IFACE_COUNT;
				end
				OFS_IDENT:   s_d.prdata = s_q.ident;
				default:     s_d.pslverr = 1'b1;
			endcase
		end

		// Host requests take effect at the completing edge
		if (commit) begin
			case (paddr)
				OFS_CTRL: if (pwrite) s_d.flow_en = pwdata[B_FLOW_EN];
				OFS_USB_EVT: if (pwrite) begin
					if (pwdata[B_EV_SUSP])
						s_d.suspended = 1'b1;
					if (pwdata[B_EV_RESUME] | pwdata[B_EV_BUSRST] | pwdata[B_EV_WAKE])
						s_d.suspended = 1'b0;
				end
				OFS_RATE: if (pwrite && !s_q.div_busy && pwdata != '0) begin
					s_d.div_busy = 1'b1;
					s_d.req_rate = pwdata;
					s_d.div_step = 5'h17;
					s_d.quo      = '0;
					s_d.rem      = '0;
				end
				OFS_TXDATA: if (pwrite) begin
					if (s_q.tx_cnt != FIFO_FULL) begin
						tx_push = 1'b1;
						s_d.txm[ring_idx(s_q.tx_rd, s_q.tx_cnt)] = pwdata[7:0];
					end else begin
						s_d.tx_drop = 1'b1;
					end
				end
				OFS_RXDATA: if (!pwrite && s_q.rx_cnt != '0) rx_pop = 1'b1;
				OFS_STATUS: if (pwrite) begin
					if (pwdata[B_ST_TXDROP]) s_d.tx_drop = 1'b0;
					if (pwdata[B_ST_RXOVF])  s_d.rx_ovf = 1'b0;
				end
				OFS_IDENT: if (pwrite) s_d.ident = pwdata;
				default: ;
			endcase
		end

		// Restoring divider: quotient of 12 MHz by the requested rate
		if (s_q.div_busy) begin
			rem_sh = {s_q.rem[31:0], REF_HZ[s_q.div_step]};
			if (rem_sh >= {1'b0, s_q.req_rate}) begin
				s_d.rem = rem_sh - {1'b0, s_q.req_rate};
				s_d.quo[s_q.div_step] = 1'b1;
			end else begin
				s_d.rem = rem_sh;
			end
			s_d.div_step = s_q.div_step - 5'h01;
			if (s_q.div_step == '0) begin
				s_d.div_busy = 1'b0;
				// Rates above the reference clamp to one tick per bit
				s_d.div  = (s_d.quo == '0) ? 24'h000001 : s_d.quo;
				s_d.rate = s_q.req_rate;
			end
		end

		// Transmitter
		case (s_q.tx_st)
			TX_IDLE: begin
				s_d.txd = 1'b1;
				if (s_q.tx_cnt != '0 && cts_clear) begin
					tx_pop    = 1'b1;
					s_d.tx_sh = s_q.txm[s_q.tx_rd];
					s_d.tx_rd = s_q.tx_rd + 6'h01;
					s_d.tx_bc = s_q.div - 24'h000001;
					s_d.txd   = 1'b0;
					s_d.tx_st = TX_START;
				end
			end
			TX_START, TX_DATA: if (s_q.ref_tick) begin
				// CTS is not looked at here, so a started character completes
				if (s_q.tx_bc != '0) begin
					s_d.tx_bc = s_q.tx_bc - 24'h000001;
				end else begin
					s_d.tx_bc = s_q.div - 24'h000001;
					if (s_q.tx_st == TX_DATA && s_q.tx_bit == 3'h7) begin
						s_d.txd   = 1'b1;
						s_d.tx_st = TX_STOP;
					end else begin
						s_d.txd    = s_q.tx_sh[0];
						s_d.tx_sh  = {1'b0, s_q.tx_sh[7:1]};
						s_d.tx_bit = (s_q.tx_st == TX_DATA) ? s_q.tx_bit + 3'h1 : 3'h0;
						s_d.tx_st  = TX_DATA;
					end
				end
			end
			TX_STOP: if (s_q.ref_tick) begin
				if (s_q.tx_bc != '0) s_d.tx_bc = s_q.tx_bc - 24'h000001;
				else s_d.tx_st = TX_IDLE;
			end
			default: s_d.tx_st = TX_IDLE;
		endcase

		// Receiver
		case (s_q.rx_st)
			RX_IDLE: if (s_q.rx_sync[2] && !s_q.rx_sync[1]) begin
				s_d.rx_bc = {1'b0, s_q.div[23:1]};
				s_d.rx_st = RX_START;
			end
			RX_START: if (s_q.ref_tick) begin
				if (s_q.rx_bc != '0) begin
					s_d.rx_bc = s_q.rx_bc - 24'h000001;
				end else begin
					// A glitch shorter than half a bit is not a start bit
					s_d.rx_st  = s_q.rx_sync[1] ? RX_IDLE : RX_DATA;
					s_d.rx_bc  = s_q.div - 24'h000001;
					s_d.rx_bit = 3'h0;
				end
			end
			RX_DATA: if (s_q.ref_tick) begin
				if (s_q.rx_bc != '0) begin
					s_d.rx_bc = s_q.rx_bc - 24'h000001;
				end else begin
					s_d.rx_sh  = {s_q.rx_sync[1], s_q.rx_sh[7:1]};
					s_d.rx_bc  = s_q.div - 24'h000001;
					s_d.rx_bit = s_q.rx_bit + 3'h1;
					if (s_q.rx_bit == 3'h7) s_d.rx_st = RX_STOP;
				end
			end
			RX_STOP: if (s_q.ref_tick) begin
				if (s_q.rx_bc != '0) begin
					s_d.rx_bc = s_q.rx_bc - 24'h000001;
				end else begin
					s_d.rx_st = RX_IDLE;
					// Serial data only ever lands in the buffer
					rx_push = s_q.rx_sync[1];
				end
			end
			default: s_d.rx_st = RX_IDLE;
		endcase

		if (rx_push) begin
			if (s_q.rx_cnt != FIFO_FULL) begin
				s_d.rxm[ring_idx(s_q.rx_rd, s_q.rx_cnt)] = s_q.rx_sh;
			end else begin
				// Pointer frozen, last slot reused
				s_d.rxm[ring_idx(s_q.rx_rd, LAST_SLOT)] = s_q.rx_sh;
				s_d.rx_ovf = 1'b1;
			end
		end
		if (rx_pop) s_d.rx_rd = s_q.rx_rd + 6'h01;
		s_d.rx_cnt = cnt_next(s_q.rx_cnt, rx_push && s_q.rx_cnt != FIFO_FULL, rx_pop);
		s_d.tx_cnt = cnt_next(s_q.tx_cnt, tx_push, tx_pop);

		// Next-state enable, so rts_n never lags a change of the control bit
		s_d.rts_n = s_d.flow_en & (s_d.rx_cnt >= RTS_TRIP);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.rate      <= START_RATE_P;
			s_q.div       <= 24'(REF_HZ / START_RATE_P);
			s_q.ident     <= {VENDOR_ID, PRODUCT_ID};
			s_q.txd       <= 1'b1;
			s_q.rx_sync   <= 3'h7;
			s_q.cts_sync  <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata  = s_q.prdata;
	assign pready  = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign tx      = s_q.txd;
	assign rts_n   = s_q.rts_n;

	// Checks
	logic apb_commit;
	assign apb_commit = psel & penable & s_q.pready;

	chk_rts_trip: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.flow_en && s_q.rx_cnt >= RTS_TRIP |-> s_q.rts_n)
		else $error("rts_n low with 63 or more characters buffered");
	chk_rts_ready: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.rx_cnt < RTS_TRIP |-> !s_q.rts_n)
		else $error("rts_n high while receive space remains");
	chk_cts_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tx_st == TX_IDLE && s_q.flow_en && s_q.cts_sync[1] |=> s_q.tx_st == TX_IDLE)
		else $error("character started while cts_n high");
	chk_tx_complete: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tx_st == TX_START |=> s_q.tx_st != TX_IDLE)
		else $error("started character abandoned");
	chk_rx_full_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.rx_cnt == FIFO_FULL && !apb_commit |=> s_q.rx_cnt == FIFO_FULL && $stable(s_q.rx_rd))
		else $error("full receive buffer pointer moved");
	chk_div_result: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_q.div_busy) |-> s_q.div == ((REF_HZ / s_q.rate == 0) ? 24'h000001
			: 24'(REF_HZ / s_q.rate)))
		else $error("divisor differs from reference over rate");
	chk_fmt_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		apb_commit && paddr == OFS_FMT |-> prdata == FMT_WORD)
		else $error("line format not 8N1");
	chk_resume_exit: assert property (@(posedge pclk) disable iff (!presetn)
		apb_commit && pwrite && paddr == OFS_USB_EVT && pwdata[B_EV_RESUME] |=> !s_q.suspended)
		else $error("suspend not left on resume");
	chk_start_bit: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.tx_st == TX_IDLE ##1 s_q.tx_st == TX_START |-> !tx ##1 !tx)
		else $error("start bit not low");
	chk_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready |=> pready)
		else $error("APB answer later than one wait state");

	cov_tx_char: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.tx_st == TX_STOP ##1 s_q.tx_st == TX_IDLE);
	cov_rx_overflow: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(s_q.rx_ovf));
	cov_rate_change: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(s_q.div_busy));
	cov_cts_stall: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.tx_st == TX_IDLE && s_q.tx_cnt != '0 && s_q.flow_en && s_q.cts_sync[1]);

endmodule

// file: core/u2ub_pkg.sv
/*
  Shared constants and types of the serial bridge core: register map,
  field positions, reset values, reference-clock figures and state codes.
  Assumes a single 100 MHz bus clock and a 32-bit APB register bus.
*/
package u2ub_pkg;

	// Clocks, in MHz and Hz
	localparam logic [7:0]  CLK_MHZ   = 8'h64;
	localparam logic [7:0]  REF_MHZ   = 8'h0C;
	localparam logic [23:0] REF_HZ    = 24'hB71B00;

	// Line coding reset values and fixed frame
	localparam logic [31:0] START_RATE = 32'h0000_4B00;
	localparam logic [23:0] START_DIV  = 24'(REF_HZ / START_RATE);
	localparam logic [7:0]  DATA_BITS  = 8'h08;
	localparam logic [7:0]  PARITY_NONE = 8'h00;
	localparam logic [7:0]  STOP_ONE   = 8'h00;
	localparam logic [31:0] FMT_WORD   = {8'h00, DATA_BITS, PARITY_NONE, STOP_ONE};

	// Buffers
	localparam int          FIFO_DEPTH = 64;
	localparam logic [6:0]  FIFO_FULL  = 7'h40;
	localparam logic [6:0]  RTS_TRIP   = 7'h3F;
	localparam logic [6:0]  LAST_SLOT  = 7'h3F;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_USB_EVT = 8'h04;
	localparam logic [7:0] OFS_RATE    = 8'h08;
	localparam logic [7:0] OFS_FMT     = 8'h0C;
	localparam logic [7:0] OFS_DIV     = 8'h10;
	localparam logic [7:0] OFS_TXDATA  = 8'h14;
	localparam logic [7:0] OFS_RXDATA  = 8'h18;
	localparam logic [7:0] OFS_STATUS  = 8'h1C;
	localparam logic [7:0] OFS_IDENT   = 8'h20;

	// Field positions
	localparam int B_FLOW_EN   = 0;
	localparam int B_EV_SUSP   = 0;
	localparam int B_EV_RESUME = 1;
	localparam int B_EV_BUSRST = 2;
	localparam int B_EV_WAKE   = 3;
	localparam int B_RX_VALID  = 8;
	localparam int B_ST_SUSP   = 16;
	localparam int B_ST_BUSY   = 17;
	localparam int B_ST_CTS    = 18;
	localparam int B_ST_RTS    = 19;
	localparam int B_ST_TXDROP = 20;
	localparam int B_ST_RXOVF  = 21;
	localparam logic [1:0] IFACE_COUNT = 2'h2;

	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_START = 2'h1,
		TX_DATA  = 2'h3,
		TX_STOP  = 2'h2
	} u2ub_tx_st_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'h0,
		RX_START = 2'h1,
		RX_DATA  = 2'h3,
		RX_STOP  = 2'h2
	} u2ub_rx_st_t;

endpackage

// file: verif/u2ub_core_tb.sv
/*
  Self-checking bench of the serial bridge core: register face, line rate,
  transmit under clear-to-send, receive buffer and request-to-send.
  Assumes the core, its package and the serial peer model compile first.
*/
`timescale 1ns/1ps
module u2ub_core_tb
	import u2ub_pkg::*;
;
	typedef struct {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic        er;
	} u2ub_row_t;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rx;
	logic        tx;
	logic        cts_n;
	logic        rts_n;
	logic [31:0] rd;
	logic        er;
	int          n_errors;
	int          n_tests;
	u2ub_row_t   rows[$];
	logic [31:0] rates[$];

	u2ub_core i_dut (
		.pclk    (pclk),
		.presetn (presetn),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rx      (rx),
		.tx      (tx),
		.cts_n   (cts_n),
		.rts_n   (rts_n)
	);

	u2ub_peer i_peer (
		.tx    (tx),
		.rx    (rx),
		.cts_n (cts_n)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Request is held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50)
			chk("apb_ready", 32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic void row(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e,
		logic er);
		rows.push_back('{w, a, d, e, er});
	endfunction

	// A write during the divider's busy time is dropped, so poll it out
	task automatic set_rate(input logic [31:0] r);
		apb(1'b1, OFS_RATE, r);
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, OFS_STATUS, 32'h0);
			if (rd[B_ST_BUSY] === 1'b0)
				break;
		end
	endtask

	task automatic rd_rx(input logic [8:0] exp);
		apb(1'b0, OFS_RXDATA, 32'h0);
		chk("rx_data", {23'h0, rd[8:0]}, {23'h0, exp});
	endtask

	task automatic wait_got(input int n);
		for (int i = 0; i < 3000 && i_peer.got_q.size() < n; i++)
			@(posedge pclk);
	endtask

	task automatic test_done();
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#900000;
		n_errors++;
		test_done();
	end

	initial begin
		n_errors = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		chk("tx_idle", {31'h0, tx}, 32'h1);
		chk("rts_idle", {31'h0, rts_n}, 32'h0);
		presetn <= 1'b1;
		row(1'b0, 8'h08, 32'h0, 32'h0000_4B00, 1'b0);
		row(1'b0, 8'h0C, 32'h0, 32'h0008_0000, 1'b0);
		row(1'b0, 8'h10, 32'h0, 32'h0000_0271, 1'b0);
		row(1'b0, 8'h20, 32'h0, 32'h1234_5678, 1'b0);
		row(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
		row(1'b0, 8'h1C, 32'h0, 32'h0200_0000, 1'b0);
		row(1'b1, 8'h24, 32'h1, 32'h0, 1'b1);
		row(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
		row(1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'b0);
		row(1'b0, 8'h0C, 32'h0, 32'h0008_0000, 1'b0);
		row(1'b1, 8'h20, 32'hAABB_CCDD, 32'h0, 1'b0);
		row(1'b0, 8'h20, 32'h0, 32'hAABB_CCDD, 1'b0);
		for (logic [31:0] ev = 32'h1; ev < 32'h10; ev = ev << 1) begin
			row(1'b1, 8'h04, 32'h1, 32'h0, 1'b0);
			row(1'b0, 8'h04, 32'h0, 32'h1, 1'b0);
			row(1'b1, 8'h04, ev | 32'h1, 32'h0, 1'b0);
			row(1'b0, 8'h04, 32'h0, {31'h0, ev == 32'h1}, 1'b0);
		end
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk("slverr", {31'h0, er}, {31'h0, rows[i].er});
			if (!rows[i].w && !rows[i].er)
				chk("reg_read", rd, rows[i].e);
		end
		rates = '{32'h12C, 32'h4B0, 32'h960, 32'h12C0, 32'h2580, 32'h4B00, 32'h9600,
			32'hE100, 32'h1C200, 32'h38400, 32'h70800, 32'hE1000, 32'h186A0};
		foreach (rates[i]) begin
			set_rate(rates[i]);
			apb(1'b0, OFS_DIV, 32'h0);
			chk("divisor", rd, 32'h00B7_1B00 / rates[i]);
			apb(1'b0, OFS_RATE, 32'h0);
			chk("rate", rd, rates[i]);
		end
		apb(1'b1, OFS_RATE, 32'h1C200);
		set_rate(32'h2580);
		set_rate(32'h0);
		apb(1'b0, OFS_DIV, 32'h0);
		chk("div_busy", rd, 32'h68);
		set_rate(32'h002D_C6C0);
		apb(1'b0, OFS_DIV, 32'h0);
		chk("div_fast", rd, 32'h4);
		apb(1'b1, OFS_TXDATA, 32'hA5);
		apb(1'b1, OFS_TXDATA, 32'h3C);
		wait_got(2);
		chk("tx0", {24'h0, i_peer.got_q.pop_front()}, 32'hA5);
		chk("tx1", {24'h0, i_peer.got_q.pop_front()}, 32'h3C);
		apb(1'b1, OFS_CTRL, 32'h1);
		i_peer.set_cts(1'b1);
		apb(1'b1, OFS_TXDATA, 32'h96);
		repeat (400) @(posedge pclk);
		chk("tx_held", {31'h0, tx}, 32'h1);
		i_peer.set_cts(1'b0);
		wait_got(1);
		chk("tx_freed", {24'h0, i_peer.got_q.pop_front()}, 32'h96);
		apb(1'b1, OFS_TXDATA, 32'hC3);
		@(negedge tx);
		i_peer.set_cts(1'b1);
		wait_got(1);
		chk("tx_done", {24'h0, i_peer.got_q.pop_front()}, 32'hC3);
		i_peer.set_cts(1'b0);
		i_peer.send(8'h77, 1'b0);
		i_peer.send(8'h5A, 1'b1);
		rd_rx(9'h15A);
		apb(1'b0, OFS_RXDATA, 32'h0);
		chk("rx_empty", {31'h0, rd[B_RX_VALID]}, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h0);
		for (int i = 0; i < 65; i++)
			i_peer.send(8'(i), 1'b1);
		chk("rts_off", {31'h0, rts_n}, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("rx_count", {25'h0, rd[14:8]}, 32'h40);
		chk("rx_ovf", {31'h0, rd[B_ST_RXOVF]}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'h1 << B_ST_RXOVF);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("rx_ovf_clr", {31'h0, rd[B_ST_RXOVF]}, 32'h0);
		apb(1'b0, OFS_RATE, 32'h0);
		chk("rate_kept", rd, 32'h002D_C6C0);
		for (int i = 0; i < 64; i++)
			rd_rx({1'b1, (i < 63) ? 8'(i) : 8'h40});
		apb(1'b1, OFS_CTRL, 32'h1);
		for (int i = 0; i < 62; i++)
			i_peer.send(8'(i), 1'b1);
		chk("rts_room", {31'h0, rts_n}, 32'h0);
		i_peer.send(8'hEE, 1'b1);
		chk("rts_trip", {31'h0, rts_n}, 32'h1);
		rd_rx(9'h100);
		repeat (2) @(posedge pclk);
		chk("rts_back", {31'h0, rts_n}, 32'h0);
		for (int i = 1; i < 62; i++)
			rd_rx({1'b1, 8'(i)});
		rd_rx(9'h1EE);
		apb(1'b1, OFS_USB_EVT, 32'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_USB_EVT, 32'h0);
		chk("susp_reset", rd, 32'h0);
		apb(1'b0, OFS_IDENT, 32'h0);
		chk("ident_reset", rd, 32'h1234_5678);
		chk("frame_err", 32'(i_peer.n_frame_err), 32'h0);
		test_done();
	end
endmodule

// file: verif/u2ub_peer.sv
/*
  Serial peer model: an 8N1 partner with a clear-to-send output.
  Assumes the core's tx and rx lines idle high and a bit time of 1/3 us.
*/
`timescale 1ns/1ps
module u2ub_peer (
	// Serial lines
	input  wire logic tx,
	output logic      rx,
	output logic      cts_n
);
	real        bit_ns;
	logic [7:0] cap;
	logic [7:0] got_q[$];
	int         n_frame_err;

	initial begin
		bit_ns = 1000.0 / 3.0;
		n_frame_err = 0;
		rx = 1'b1;
		cts_n = 1'b0;  // Ready to take data
	end

	task automatic set_cts(input logic v);
		cts_n = v;
	endtask

	// A low stop bit goes out only when a test asks for a broken frame
	task automatic send(input logic [7:0] b, input logic stop_ok);
		rx = 1'b0;
		#(bit_ns);
		for (int i = 0; i < 8; i++) begin
			rx = b[i];
			#(bit_ns);
		end
		rx = stop_ok;
		#(bit_ns);
		rx = 1'b1;
		#(bit_ns);
	endtask

	// Half-bit offset absorbs a start bit up to one reference tick short
	always begin
		@(negedge tx);
		#(bit_ns * 1.5);
		for (int i = 0; i < 8; i++) begin
			cap[i] = tx;
			#(bit_ns);
		end
		if (tx !== 1'b1)
			n_frame_err++;
		got_q.push_back(cap);
	end
endmodule
